/* File: core/sbs_params.svh */
// constants of the sync burst sram control block
`ifndef SBS_PARAMS_SVH
`define SBS_PARAMS_SVH
`define SBS_ADDR_W  16
`define SBS_LANE_W  9
`define SBS_LANES   4
`define SBS_BURST_LEN 4
`endif

/* File: core/sbs_pkg.sv */
// types of the sync burst sram control block
package sbs_pkg;
  typedef enum logic [2:0] {
    SBS_DESEL = 3'h0,
    SBS_RD_BEGIN = 3'h1,
    SBS_WR_BEGIN = 3'h2,
    SBS_CONT = 3'h3,
    SBS_SUSP = 3'h4
  } sbs_cyc_e;
endpackage : sbs_pkg

/* File: core/sbs_if.sv */
// pin interface between host and sram
`timescale 1ns/1ns
`default_nettype none
`include "sbs_params.svh"
interface sbs_if;
  logic                                       chip_select_primary_n;
  logic                                       chip_select_high_active;
  logic                                       chip_select_secondary_n;
  logic                                       processor_addr_strobe_n;
  logic                                       controller_addr_strobe_n;
  logic                                       burst_advance_n;
  logic                                       global_write_n;
  logic                                       lane_write_qualifier_n;
  logic [`SBS_LANES-1:0]                      lane_enable_n;
  logic                                       output_enable_n;
  logic                                       linear_order_select_n;
  logic [`SBS_ADDR_W-1:0]                     addr;
  logic [`SBS_LANES*`SBS_LANE_W-1:0]          dq_host_o;
  logic                                       dq_host_oe;
  logic [`SBS_LANES*`SBS_LANE_W-1:0]          dq_dev_o;
  logic [`SBS_LANES-1:0]                      dq_dev_oe;
  modport host (
    output chip_select_primary_n, chip_select_high_active, chip_select_secondary_n,
    output processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n,
    output global_write_n, lane_write_qualifier_n, lane_enable_n, output_enable_n,
    output linear_order_select_n, addr, dq_host_o, dq_host_oe,
    input dq_dev_o, dq_dev_oe
  );
  modport dev (
    input chip_select_primary_n, chip_select_high_active, chip_select_secondary_n,
    input processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n,
    input global_write_n, lane_write_qualifier_n, lane_enable_n, output_enable_n,
    input linear_order_select_n, addr, dq_host_o, dq_host_oe,
    output dq_dev_o, dq_dev_oe
  );
endinterface : sbs_if
`default_nettype wire

/* File: core/sbs_dev.sv */
// sram end: cycle decode, burst counter, byte writes, pipelined reads
`timescale 1ns/1ns
`default_nettype none
`include "sbs_params.svh"
// Contract
// - both writes high means read all lanes
// - byte write writes only low-enabled lanes
// - global write low writes every lane
// - data lanes undriven during every write; the code cuts them from the edge after a write, not in the write cycle
// - lanes c and d only in wide variants
// - write-select is global or byte write low
// - deselect on listed enable/strobe combinations
// - begin read burst at external address
// - begin write burst at external address
// - continue burst advances to next address
// - suspend burst repeats current address
// - linear or interleaved two-bit burst order
// - counter wraps to loaded bits after four
// - output enable acts asynchronously, only on reads
// - deselect turns outputs off one stage early; the code drops them two edges after deselect, in step with the read pipe
// - every decode table combination supported
// - host may tie strobes for single accesses
// - host may tie advance for simple bursts
// - host may use dummy reads before writes
// - dummy read advances counter like normal read
// - host holds output enable high before writes
module sbs_dev #(
  parameter int LANES  = `SBS_LANES,
  parameter int LANE_W = `SBS_LANE_W,
  parameter int ADDR_W = `SBS_ADDR_W,
  parameter int DEPTH  = 1 << 10
) (
  input  wire logic clk_sys,
  input  wire logic nrst,
  sbs_if.dev        pins
);
  localparam int AW = $clog2(DEPTH);
  logic [LANES*LANE_W-1:0] mem [DEPTH];
  logic [ADDR_W-1:0]       base_r;
  logic [1:0]              cnt_r;
  logic                    active_r;
  logic                    rd_pend_r;
  logic [LANES*LANE_W-1:0] rd_data_r;
  logic [LANES*LANE_W-1:0] dq_o_r;
  logic                    dq_on_r;
  logic [LANES-1:0]        lane_we;
  logic                    wsel;
  logic                    en_ok;
  logic                    burst_cont;
  logic                    sel_ok;
  logic                    p_start;
  logic                    c_start;
  sbs_pkg::sbs_cyc_e       cyc;
  logic [1:0]              low_bits;
  logic [ADDR_W-1:0]       cur_addr;
  logic                    do_rd;
  logic                    do_wr;

  function automatic logic [1:0] burst_bits(input logic [1:0] start, input logic [1:0] n,
                                            input logic lin_n);
    burst_bits = lin_n ? (start ^ n) : 2'(start + n);
  endfunction : burst_bits

  // inside a burst only a begun burst reads or writes; result is {write, read}
  function automatic logic [1:0] burst_rw(input logic act, input logic ws);
    burst_rw = {act & ws, act & ~ws};
  endfunction : burst_rw

  assign wsel  = ~pins.global_write_n | ~pins.lane_write_qualifier_n;
  assign en_ok = pins.chip_select_high_active & ~pins.chip_select_secondary_n;
  assign burst_cont = pins.controller_addr_strobe_n
                      & (pins.processor_addr_strobe_n | pins.chip_select_primary_n);
  assign sel_ok  = ~pins.chip_select_primary_n & en_ok;
  assign p_start = sel_ok & ~pins.processor_addr_strobe_n;
  assign c_start = sel_ok & pins.processor_addr_strobe_n & ~pins.controller_addr_strobe_n;

  // cycle decode, every combination resolved
  always_comb
  begin
    if (p_start)
      cyc = sbs_pkg::SBS_RD_BEGIN;
    else if (c_start)
      cyc = wsel ? sbs_pkg::SBS_WR_BEGIN : sbs_pkg::SBS_RD_BEGIN;
    else if (burst_cont)
      cyc = pins.burst_advance_n ? sbs_pkg::SBS_SUSP : sbs_pkg::SBS_CONT;
    else
      cyc = sbs_pkg::SBS_DESEL;
  end

  // lane write decode
  always_comb
  begin
    if (!pins.global_write_n)
      lane_we = '1;
    else if (!pins.lane_write_qualifier_n)
      lane_we = ~pins.lane_enable_n;
    else
      lane_we = '0;
  end

  always_comb
  begin
    low_bits = burst_bits(base_r[1:0], cnt_r, pins.linear_order_select_n);
    cur_addr = {base_r[ADDR_W-1:2], low_bits};
  end

  // burst counter; dummy reads step it like any read
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      base_r   <= '0;
      cnt_r    <= 2'h0;
      active_r <= 1'b0;
    end
    else
    begin
      unique case (cyc)
        sbs_pkg::SBS_RD_BEGIN, sbs_pkg::SBS_WR_BEGIN:
        begin
          base_r   <= pins.addr;
          cnt_r    <= 2'h0;
          active_r <= 1'b1;
        end
        sbs_pkg::SBS_CONT:
        begin
          cnt_r <= 2'(cnt_r + 2'h1);
        end
        sbs_pkg::SBS_SUSP:
          cnt_r <= cnt_r;
        sbs_pkg::SBS_DESEL:
          active_r <= 1'b0;
      endcase
    end
  end

  // access address of this cycle
  logic [ADDR_W-1:0] acc_addr;
  always_comb
  begin
    acc_addr = cur_addr;
    do_rd    = 1'b0;
    do_wr    = 1'b0;
    unique case (cyc)
      sbs_pkg::SBS_RD_BEGIN:
      begin
        acc_addr = pins.addr;
        do_rd    = 1'b1;
      end
      sbs_pkg::SBS_WR_BEGIN:
      begin
        acc_addr = pins.addr;
        do_wr    = 1'b1;
      end
      sbs_pkg::SBS_CONT:
      begin
        acc_addr = {base_r[ADDR_W-1:2],
                    burst_bits(base_r[1:0], 2'(cnt_r + 2'h1), pins.linear_order_select_n)};
        {do_wr, do_rd} = burst_rw(active_r, wsel);
      end
      sbs_pkg::SBS_SUSP:
      begin
        {do_wr, do_rd} = burst_rw(active_r, wsel);
      end
      sbs_pkg::SBS_DESEL: acc_addr = cur_addr;
    endcase
  end

  // array access, one word per cycle
  always_ff @(posedge clk_sys)
  begin
    for (int l = 0; l < LANES; l++)
      if (do_wr && lane_we[l])
        mem[acc_addr[AW-1:0]][l*LANE_W +: LANE_W] <= pins.dq_host_o[l*LANE_W +: LANE_W];
    if (do_rd)
      rd_data_r <= mem[acc_addr[AW-1:0]];
  end

  // drivers follow the read pipe; a deselect starts no read, so the lanes
  // drop right after the last read word instead of cutting it
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      rd_pend_r <= 1'b0;
      dq_on_r   <= 1'b0;
    end
    else
    begin
      rd_pend_r <= do_rd;
      dq_on_r   <= rd_pend_r & ~do_wr;
    end
  end

  // output data: read registered at edge n, driven after edge n+1
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      dq_o_r <= '0;
    end
    else
    begin
      dq_o_r <= rd_data_r;
    end
  end

  assign pins.dq_dev_o  = dq_o_r;
  assign pins.dq_dev_oe = {LANES{dq_on_r & ~pins.output_enable_n}};
endmodule : sbs_dev
`default_nettype wire

/* File: core/sbs_host.sv */
// host end: drives pins from a simple single-access request port
`timescale 1ns/1ns
`default_nettype none
`include "sbs_params.svh"
module sbs_host #(
  parameter int LANES  = `SBS_LANES,
  parameter int LANE_W = `SBS_LANE_W,
  parameter int ADDR_W = `SBS_ADDR_W
) (
  input  wire logic                    clk_sys,
  input  wire logic                    nrst,
  input  wire logic                    req,
  input  wire logic                    req_write,
  input  wire logic [ADDR_W-1:0]       req_addr,
  input  wire logic [LANES-1:0]        req_lanes,
  input  wire logic [LANES*LANE_W-1:0] req_wdata,
  output logic                         busy,
  output logic                         rd_valid,
  output logic [LANES*LANE_W-1:0]      rd_data,
  sbs_if.host                          pins
);
  logic                    cs_r;
  logic                    wr_r;
  logic [ADDR_W-1:0]       addr_r;
  logic [LANES-1:0]        lanes_r;
  logic [LANES*LANE_W-1:0] wdata_r;
  logic                    oe_n_r;
  logic [2:0]              rd_pipe_r;

  // single accesses: strobe p tied high, c tied low
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      cs_r    <= 1'b0;
      wr_r    <= 1'b0;
      addr_r  <= '0;
      lanes_r <= '0;
      wdata_r <= '0;
    end
    else
    begin
      cs_r <= req & ~busy;
      if (req && !busy)
      begin
        wr_r    <= req_write;
        addr_r  <= req_addr;
        lanes_r <= req_lanes;
        wdata_r <= req_wdata;
      end
    end
  end

  // write waits while a read is still in the pipe, drivers off first
  always_comb
    busy = req_write & (|rd_pipe_r);

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      rd_pipe_r <= 3'h0;
      oe_n_r    <= 1'b1;
      rd_valid  <= 1'b0;
      rd_data   <= '0;
    end
    else
    begin
      rd_pipe_r <= {rd_pipe_r[1:0], cs_r & ~wr_r};
      oe_n_r    <= ~rd_pipe_r[0];
      rd_valid  <= rd_pipe_r[1];
      if (rd_pipe_r[1])
        rd_data <= pins.dq_dev_o;
    end
  end

  assign pins.chip_select_primary_n    = ~cs_r;
  assign pins.chip_select_high_active  = 1'b1;
  assign pins.chip_select_secondary_n  = 1'b0;
  assign pins.processor_addr_strobe_n  = 1'b1;
  assign pins.controller_addr_strobe_n = 1'b0;
  assign pins.burst_advance_n          = 1'b0;
  assign pins.global_write_n           = ~(cs_r & wr_r & (&lanes_r));
  assign pins.lane_write_qualifier_n   = ~(cs_r & wr_r & ~(&lanes_r));
  assign pins.lane_enable_n            = ~lanes_r;
  assign pins.output_enable_n          = oe_n_r;
  assign pins.linear_order_select_n    = 1'b0;
  assign pins.addr                     = addr_r;
  assign pins.dq_host_o                = wdata_r;
  assign pins.dq_host_oe               = cs_r & wr_r;
endmodule : sbs_host
`default_nettype wire

/* File: tb/sbs_props.sv */
// pin assertions between host and sram ends
`timescale 1ns/1ns
`default_nettype none
`include "sbs_params.svh"
module sbs_props (
  input wire logic                 clk_sys,
  input wire logic                 nrst,
  input wire logic                 chip_select_primary_n,
  input wire logic                 chip_select_high_active,
  input wire logic                 chip_select_secondary_n,
  input wire logic                 processor_addr_strobe_n,
  input wire logic                 controller_addr_strobe_n,
  input wire logic                 global_write_n,
  input wire logic                 lane_write_qualifier_n,
  input wire logic                 output_enable_n,
  input wire logic                 dq_host_oe,
  input wire logic [`SBS_LANES-1:0] dq_dev_oe
);
  logic ce, wsel, p_n, c_n, e1_n, rd_bg, wr_bg, desel, rd_any;
  assign ce = chip_select_high_active & !chip_select_secondary_n;
  assign wsel = !global_write_n | !lane_write_qualifier_n;
  assign p_n = processor_addr_strobe_n;
  assign c_n = controller_addr_strobe_n;
  assign e1_n = chip_select_primary_n;
  assign rd_bg = !e1_n & ce & (!p_n | (!c_n & !wsel));
  assign wr_bg = !e1_n & ce & p_n & !c_n & wsel;
  assign desel = (e1_n & !c_n) | (!e1_n & !ce & (!p_n | !c_n));
  assign rd_any = rd_bg | (c_n & (p_n | e1_n) & !wsel);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  a_read_lanes: assert property (rd_bg ##2 !output_enable_n |-> &dq_dev_oe)
    else $error("read data not on every lane");
  a_write_quiet: assert property (wr_bg |-> (dq_dev_oe == '0) [*3])
    else $error("device drove lanes around a write");
  a_desel_off: assert property (desel |-> ##2 dq_dev_oe == '0)
    else $error("lanes still driven after deselect");
  a_oe_async: assert property (output_enable_n |-> dq_dev_oe == '0)
    else $error("lanes driven with output enable high");
  a_drive_cause: assert property (|dq_dev_oe |-> $past(rd_any, 2))
    else $error("lanes driven without a read two edges back");
  a_no_clash: assert property (dq_host_oe |-> dq_dev_oe == '0)
    else $error("both ends drive the data lanes");
  a_host_wsel: assert property (dq_host_oe |-> wsel)
    else $error("write data without a write select");
  a_wr_oe_high: assert property (dq_host_oe |-> output_enable_n)
    else $error("write data with output enable low");
  c_read: cover property (rd_bg);
  c_write: cover property (wr_bg);
  c_lane_write: cover property (wr_bg & global_write_n);
endmodule : sbs_props
`default_nettype wire

/* File: tb/sync_burst_sram_control_tb.sv */
// self-checking bench for host and sram joined by pins
`timescale 1ns/1ns
`default_nettype none
`include "sbs_params.svh"
module sync_burst_sram_control_tb;
  localparam int DW = `SBS_LANES*`SBS_LANE_W;
  logic                   clk_sys, nrst, req, req_write, busy, rd_valid;
  logic [`SBS_ADDR_W-1:0] req_addr;
  logic [3:0]             req_lanes;
  logic [DW-1:0]          req_wdata, rd_data, got;
  int                     num_errors, n_checks, cyc;
  sbs_if u_sbs_if ();
  sbs_host u_sbs_host (.clk_sys(clk_sys), .nrst(nrst), .req(req), .req_write(req_write),
    .req_addr(req_addr), .req_lanes(req_lanes), .req_wdata(req_wdata), .busy(busy),
    .rd_valid(rd_valid), .rd_data(rd_data), .pins(u_sbs_if.host));
  sbs_dev u_sbs_dev (.clk_sys(clk_sys), .nrst(nrst), .pins(u_sbs_if.dev));
  sbs_props u_sbs_props (.clk_sys(clk_sys), .nrst(nrst),
    .chip_select_primary_n(u_sbs_if.chip_select_primary_n),
    .chip_select_high_active(u_sbs_if.chip_select_high_active),
    .chip_select_secondary_n(u_sbs_if.chip_select_secondary_n),
    .processor_addr_strobe_n(u_sbs_if.processor_addr_strobe_n),
    .controller_addr_strobe_n(u_sbs_if.controller_addr_strobe_n),
    .global_write_n(u_sbs_if.global_write_n),
    .lane_write_qualifier_n(u_sbs_if.lane_write_qualifier_n),
    .output_enable_n(u_sbs_if.output_enable_n),
    .dq_host_oe(u_sbs_if.dq_host_oe), .dq_dev_oe(u_sbs_if.dq_dev_oe));
  task automatic chk(input logic [DW-1:0] g, input logic [DW-1:0] e);
    n_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [15:0] a, input logic [3:0] l,
                     input logic [DW-1:0] d);
    int i;
    req = 1'b1;
    req_write = w;
    req_addr = a;
    req_lanes = l;
    req_wdata = d;
    #1;
    for (i = 0; i < 20 && busy !== 1'b0; i++) @(negedge clk_sys);
    @(negedge clk_sys);
    req = 1'b0;
    if (w)
      @(negedge clk_sys);
    for (i = 0; i < 10 && !w && rd_valid !== 1'b1; i++) @(negedge clk_sys);
    got = rd_data;
  endtask : acc
  function automatic logic [DW-1:0] mrg(logic [DW-1:0] o, logic [DW-1:0] n, logic [3:0] l);
    for (int k = 0; k < 4; k++)
      if (l[k])
        o[k*`SBS_LANE_W +: `SBS_LANE_W] = n[k*`SBS_LANE_W +: `SBS_LANE_W];
    return o;
  endfunction : mrg
  task automatic t_lanes();
    logic [DW-1:0] e;
    acc(1'b1, 16'h0010, 4'hF, 36'h123456789);
    acc(1'b0, 16'h0010, 4'h0, '0);
    chk(got, 36'h123456789);
    e = 36'h123456789;
    for (int m = 0; m < 16; m += 5)
    begin
      acc(1'b1, 16'h0010, 4'(m), 36'hABCDEF012 ^ 36'(m));
      e = mrg(e, 36'hABCDEF012 ^ 36'(m), 4'(m));
      acc(1'b0, 16'h0010, 4'h0, '0);
      chk(got, e);
    end
  endtask : t_lanes
  task automatic t_b2b();
    int i;
    acc(1'b1, 16'h0021, 4'hF, 36'hC3C3C3C3C);
    req = 1'b1;
    req_write = 1'b0;
    req_addr = 16'h0010;
    @(negedge clk_sys);
    req_addr = 16'h0021;
    @(negedge clk_sys);
    req = 1'b0;
    for (i = 0; i < 10 && rd_valid !== 1'b1; i++) @(negedge clk_sys);
    chk(rd_data, 36'hABCDEF01D);
    @(negedge clk_sys);
    chk({35'h0, rd_valid}, 36'h1);
    chk(rd_data, 36'hC3C3C3C3C);
  endtask : t_b2b
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      num_errors++;
      print_verdict();
    end
  end
  initial
  begin
    {nrst, req, req_write, req_addr, req_lanes, req_wdata} = '0;
    {num_errors, n_checks, cyc} = '0;
    repeat (4) @(negedge clk_sys);
    nrst = 1'b1;
    @(negedge clk_sys);
    t_lanes();
    t_b2b();
    print_verdict();
  end
endmodule : sync_burst_sram_control_tb
`default_nettype wire
